//--- hdl/srmc_ctrl.sv
// Host-side controller that runs reads and writes on an asynchronous static memory
`timescale 1ns/1ns
`include "srmc_params.svh"
module srmc_ctrl
  import srmc_pkg::*;
#(
  parameter int RD_CYC   = `SRMC_RD_CYC,
  parameter int WR_CYC   = `SRMC_WR_CYC,
  parameter int TURN_CYC = `SRMC_TURN_CYC
)(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic       req_write,
  input  wire srmc_addr_t req_addr,
  input  wire srmc_data_t req_wdata,
  output logic            rsp_valid,
  output srmc_data_t      rsp_rdata,
  output logic            select_low_active_n,
  output logic            select_high_active,
  output logic            write_n,
  output logic            out_en_n,
  output srmc_addr_t      addr,
  output srmc_data_t      data_lines_out,
  output logic            data_lines_oe,
  input  wire srmc_data_t data_lines_in
);
  import srmc_pkg::*;

  // Pins pass one flop, rdata four, so reads wait for that pipe as well
  localparam int RD_WAIT = RD_CYC + 4;

  typedef struct packed {
    srmc_state_t st;
    logic [7:0]  cnt;
    logic        sel;
    logic        wr;
    logic        oe;
    logic        drv;
    srmc_addr_t  a;
    srmc_data_t  d;
    logic        rv;
    srmc_data_t  rd;
  } srmc_ctrl_t;
  srmc_ctrl_t r;
  srmc_ctrl_t next_r;

  srmc_pins_if pin ();

  srmc_pad u_pad (
    .clk                 (clk),
    .reset_n             (reset_n),
    .clk_en              (clk_en),
    .pin                 (pin.pad),
    .select_low_active_n (select_low_active_n),
    .select_high_active  (select_high_active),
    .write_n             (write_n),
    .out_en_n            (out_en_n),
    .addr                (addr),
    .data_lines_out      (data_lines_out),
    .data_lines_oe       (data_lines_oe),
    .data_lines_in       (data_lines_in)
  );

  // Requests are only taken between cycles, with the bus idle
  assign req_ready = (r.st == SRMC_IDLE) && clk_en;

  // Sequencer: writes set address first, then select/strobe; reads set all together; then release in order
  always_comb begin
    next_r    = r;
    next_r.rv = 1'b0;
    if (r.cnt != 8'h00) begin
      next_r.cnt = r.cnt - 8'h01;
    end
    case (r.st)
      SRMC_IDLE: begin
        if (req_valid) begin
          next_r.a = req_addr;             // address leads select on writes, rises with it on reads
          next_r.d = req_wdata;
          if (req_write) begin
            next_r.st  = SRMC_WR_SETUP;
            next_r.drv = 1'b1;             // memory outputs off, oe high
            next_r.oe  = 1'b0;
          end else begin
            next_r.st  = SRMC_RD_WAIT;
            next_r.sel = 1'b1;
            next_r.oe  = 1'b1;
            next_r.wr  = 1'b0;
            next_r.cnt = 8'(RD_WAIT);
          end
        end
      end
      SRMC_RD_WAIT: begin
        if (r.cnt == 8'h00) begin
          next_r.st  = SRMC_RD_DONE;
        end
      end
      SRMC_RD_DONE: begin
        next_r.rd  = pin.rdata;
        next_r.rv  = 1'b1;
        next_r.sel = 1'b0;
        next_r.oe  = 1'b0;
        next_r.st  = SRMC_TURN;            // let memory float before next drive
        next_r.cnt = 8'(TURN_CYC);
      end
      SRMC_WR_SETUP: begin
        // Both qualifiers rise together one cycle after address and data settle
        next_r.sel = 1'b1;
        next_r.wr  = 1'b1;
        next_r.cnt = 8'(WR_CYC);
        next_r.st  = SRMC_WR_PULSE;
      end
      SRMC_WR_PULSE: begin
        if (r.cnt == 8'h00) begin
          next_r.wr  = 1'b0;               // strobe ends the write
          next_r.st  = SRMC_WR_END;
        end
      end
      SRMC_WR_END: begin
        // Data and address held one cycle past the terminating edge
        next_r.sel = 1'b0;
        next_r.drv = 1'b0;
        next_r.st  = SRMC_IDLE;
      end
      SRMC_TURN: begin
        if (r.cnt == 8'h00) begin
          next_r.st = SRMC_IDLE;
        end
      end
      default: begin
        next_r.st = SRMC_IDLE;
      end
    endcase
  end

  // All state frozen while the clock enable is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{st: SRMC_IDLE, default: '0};
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign pin.select = r.sel;               // always a defined level
  assign pin.write  = r.wr;
  assign pin.out_en = r.oe;
  assign pin.drive  = r.drv;
  assign pin.addr   = r.a;
  assign pin.wdata  = r.d;
  assign rsp_valid  = r.rv;
  assign rsp_rdata  = r.rd;
endmodule

//--- hdl/srmc_pad.sv
// Registered pin stage: drives the memory pins and synchronises the data lines
`timescale 1ns/1ns
`include "srmc_params.svh"
module srmc_pad
  import srmc_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset_n,
  input  wire logic  clk_en,
  srmc_pins_if.pad   pin,
  output logic       select_low_active_n,
  output logic       select_high_active,
  output logic       write_n,
  output logic       out_en_n,
  output srmc_addr_t addr,
  output srmc_data_t data_lines_out,
  output logic       data_lines_oe,
  input  wire srmc_data_t data_lines_in
);
  typedef struct packed {
    logic       sel_n;
    logic       sel_h;
    logic       we_n;
    logic       oe_n;
    srmc_addr_t a;
    srmc_data_t d;
    logic       oe;
    srmc_data_t s1;
    srmc_data_t s2;
    srmc_data_t s3;
    srmc_data_t held;
  } srmc_pad_t;
  srmc_pad_t r;
  srmc_pad_t next_r;

  // Pins come straight from flops so no glitch reaches the memory
  always_comb begin
    next_r       = r;
    next_r.sel_n = ~pin.select;
    next_r.sel_h = pin.select;
    next_r.we_n  = ~pin.write;
    next_r.oe_n  = ~pin.out_en;
    next_r.a     = pin.addr;
    next_r.d     = pin.wdata;
    next_r.oe    = pin.drive;
    next_r.s1    = data_lines_in;
    next_r.s2    = r.s1;
    next_r.s3    = r.s2;
    // A new byte counts only once two stages agree, so a bus in transit is never taken
    if (r.s2 == r.s3) begin
      next_r.held = r.s3;
    end
  end

  // Reset leaves the memory deselected and the bus released
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{sel_n: 1'b1, sel_h: 1'b0, we_n: 1'b1, oe_n: 1'b1, default: '0};
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign select_low_active_n = r.sel_n;
  assign select_high_active  = r.sel_h;
  assign write_n             = r.we_n;
  assign out_en_n            = r.oe_n;
  assign addr                = r.a;
  assign data_lines_out      = r.d;
  assign data_lines_oe       = r.oe;
  // Data counts once second and third stages agree; the sampler holds it at read end
  assign pin.rdata           = r.held;
endmodule

//--- hdl/srmc_params.svh
// Timing and layout constants for the asynchronous static memory controller
// Overview of operation
// - The controller presents address and write data before any write begins.
// - The controller holds write data across the edge that ends the write.
// - The controller does not drive the data bus while the memory drives it.
// - The controller keeps the write strobe high through every read.
// - An address-controlled read keeps the memory selected with output enable low.
// - A select-controlled read presents the address no later than the select goes active.
// - The controller drives both select inputs to valid levels at all times.
`ifndef SRMC_PARAMS_SVH
`define SRMC_PARAMS_SVH

`define SRMC_CLK_PERIOD_NS 50
`define SRMC_ADDR_W        17
`define SRMC_DATA_W        8
// Read cycle and address to data valid, least
`define SRMC_T_RC_NS       45
`define SRMC_T_AA_NS       45
// Write strobe pulse width and data setup to write end, least
`define SRMC_T_PWE_NS      35
`define SRMC_T_SD_NS       25
// Output enable high to high impedance and strobe high to low impedance
`define SRMC_T_HZOE_NS     18
`define SRMC_T_LZWE_NS     10
// Least time to cycles: round up, never below one
`define SRMC_CYC(t) ((((t) + `SRMC_CLK_PERIOD_NS - 1) / `SRMC_CLK_PERIOD_NS) < 1 ? 1 : \
  (((t) + `SRMC_CLK_PERIOD_NS - 1) / `SRMC_CLK_PERIOD_NS))
`define SRMC_RD_CYC   `SRMC_CYC(`SRMC_T_AA_NS)
`define SRMC_WR_CYC   `SRMC_CYC(`SRMC_T_PWE_NS)
`define SRMC_TURN_CYC `SRMC_CYC(`SRMC_T_HZOE_NS)

`endif

//--- hdl/srmc_pins_if.sv
// Pin-side signals between the sequencer and the pin register stage
`timescale 1ns/1ns
interface srmc_pins_if;
  import srmc_pkg::*;
  logic       select;     // Cycle wants the memory selected
  logic       write;      // Write strobe wanted low
  logic       out_en;     // Output enable wanted low
  logic       drive;      // Controller drives data lines
  srmc_addr_t addr;
  srmc_data_t wdata;
  srmc_data_t rdata;      // Synchronised data lines
  modport seq (output select, output write, output out_en, output drive, output addr,
               output wdata, input rdata);
  modport pad (input select, input write, input out_en, input drive, input addr,
               input wdata, output rdata);
endinterface

//--- hdl/srmc_pkg.sv
// Types shared by the static memory controller modules
`include "srmc_params.svh"
package srmc_pkg;
  typedef logic [`SRMC_ADDR_W-1:0] srmc_addr_t;
  typedef logic [`SRMC_DATA_W-1:0] srmc_data_t;
  typedef enum logic [2:0] {
    SRMC_IDLE, SRMC_RD_WAIT, SRMC_RD_DONE, SRMC_WR_SETUP, SRMC_WR_PULSE, SRMC_WR_END, SRMC_TURN
  } srmc_state_t;
endpackage

//--- verif/srmc_checker.sv
// Pin protocol assertions for the static memory controller
`timescale 1ns/1ns
module srmc_checker
  import srmc_pkg::*;
#(
  parameter int RD_CYC   = 1,
  parameter int WR_CYC   = 1,
  parameter int TURN_CYC = 1
)(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       clk_en,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic       req_write,
  input wire srmc_addr_t req_addr,
  input wire srmc_data_t req_wdata,
  input wire logic       rsp_valid,
  input wire srmc_data_t rsp_rdata,
  input wire logic       select_low_active_n,
  input wire logic       select_high_active,
  input wire logic       write_n,
  input wire logic       out_en_n,
  input wire srmc_addr_t addr,
  input wire srmc_data_t data_lines_out,
  input wire logic       data_lines_oe,
  input wire srmc_data_t data_lines_in
);
  localparam int RD_LAT = RD_CYC + 7;
  logic sel;
  logic take;
  // Combined select as the memory sees it
  assign sel  = !select_low_active_n && select_high_active;
  assign take = req_valid && req_ready && clk_en;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Strobe low for two cycles, then high, then the selects drop
  sequence wr_pulse;
    ##1 !write_n ##1 write_n ##1 !sel;
  endsequence
  chk_sel_pair: assert property (select_low_active_n == !select_high_active)
    else $error("select pins disagree");
  chk_wr_qual: assert property ($fell(write_n) |-> sel && data_lines_oe)
    else $error("strobe fell unqualified");
  chk_wr_steps: assert property ($fell(write_n) |-> wr_pulse)
    else $error("write pulse shape wrong");
  chk_wr_start: assert property (take && req_write |-> ##[1:3] $fell(write_n))
    else $error("write not started");
  chk_data_hold: assert property ($rose(write_n) |-> data_lines_oe
    && $stable(data_lines_out) && $stable(addr))
    else $error("data moved at write end");
  chk_rd_strobe: assert property (!out_en_n |-> write_n)
    else $error("strobe low in read");
  chk_no_fight: assert property (!out_en_n |-> !data_lines_oe)
    else $error("bus driven during read");
  chk_addr_sel: assert property (sel && $past(sel) |-> $stable(addr))
    else $error("address moved while selected");
  chk_rd_answer: assert property (take && !req_write |-> ##[1:RD_LAT] rsp_valid)
    else $error("read answer missing");
endmodule
bind srmc_ctrl srmc_checker #(.RD_CYC(RD_CYC), .WR_CYC(WR_CYC), .TURN_CYC(TURN_CYC)) chk_u (
  .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .req_valid(req_valid),
  .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
  .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .select_low_active_n(select_low_active_n),
  .select_high_active(select_high_active), .write_n(write_n), .out_en_n(out_en_n),
  .addr(addr), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
  .data_lines_in(data_lines_in));

//--- verif/srmc_ctrl_tb_top.sv
// Self-checking bench for the static memory controller
`timescale 1ns/1ns
module srmc_ctrl_tb_top;
  import srmc_pkg::*;
  logic       clk, reset_n, req_valid, req_ready, req_write, rsp_valid;
  logic       select_low_active_n, select_high_active, write_n, out_en_n;
  logic       data_lines_oe, mem_drive;
  logic       clk_en;
  srmc_addr_t req_addr, addr, a;
  srmc_data_t req_wdata, rsp_rdata, data_lines_out, data_lines_in, mem_q, d;
  srmc_data_t float_pat = 8'h5a;
  srmc_data_t ref_mem [srmc_addr_t];
  srmc_addr_t done_q [$];
  int         failures = 0;
  int         check_count = 0;
  // Clock enable is dropped only while idle, so the pin assertions keep their timing
  srmc_ctrl dut_u (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .select_low_active_n(select_low_active_n),
    .select_high_active(select_high_active), .write_n(write_n), .out_en_n(out_en_n),
    .addr(addr), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .data_lines_in(data_lines_in));
  srmc_sram_model mem_u (.select_low_active_n(select_low_active_n),
    .select_high_active(select_high_active), .write_n(write_n), .out_en_n(out_en_n),
    .addr(addr), .data_lines(data_lines_in), .drive(mem_drive), .q(mem_q));
  // Undriven lines show a changing pattern so a stale byte never passes
  assign data_lines_in = data_lines_oe ? data_lines_out : (mem_drive ? mem_q : float_pat);
  always @(posedge clk) float_pat <= float_pat + 8'h01;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic srmc_data_t ref_rd(input srmc_addr_t x);
    return ref_mem[x];
  endfunction
  task automatic end_of_test;
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Valid stays up after the take; ready drops so the next request may follow at once
  task automatic req(input logic w, input srmc_addr_t x, input srmc_data_t y);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_write = w;
    req_addr = x;
    req_wdata = y;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #2;
      n++;
    end
    if (req_ready !== 1'b1) begin
      failures++;
      $display("MISMATCH %0t request never taken", $time);
    end
    @(posedge clk);
    #2;
  endtask
  task automatic wr(input srmc_addr_t x, input srmc_data_t y);
    req(1'b1, x, y);
    ref_mem[x] = y;
    done_q.push_back(x);
  endtask
  task automatic rd(input srmc_addr_t x);
    int n;
    n = 0;
    req(1'b0, x, 8'h00);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 30) begin
      @(posedge clk);
      #2;
      n++;
    end
    check_count++;
    if (rsp_valid !== 1'b1 || rsp_rdata !== ref_rd(x)) begin
      failures++;
      $display("MISMATCH %0t read %h got %h", $time, x, rsp_rdata);
    end
  endtask
  task automatic idle_pins;
    check_count++;
    if ({select_low_active_n, select_high_active, write_n, out_en_n, data_lines_oe}
        !== 5'b1_0110) begin
      failures++;
      $display("MISMATCH %0t pins not idle", $time);
    end
  endtask
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    {req_valid, req_write, req_addr, req_wdata} = '0;
    void'($urandom(32'h1fa3_6b64));
    repeat (10) @(posedge clk);
    #2;
    reset_n = 1'b1;
    idle_pins();
    // Address extremes and an overwrite, back to back
    wr(17'h0_0000, 8'ha5);
    wr(17'h1_ffff, 8'h3c);
    wr(17'h1_ffff, 8'hc3);
    rd(17'h0_0000);
    rd(17'h1_ffff);
    // Freeze with a write waiting: nothing may be taken and the pins stay idle
    repeat (4) @(posedge clk);
    #2;
    clk_en = 1'b0;
    req_valid = 1'b1;
    req_write = 1'b1;
    req_addr = 17'h0_0000;
    req_wdata = 8'hff;
    repeat (5) @(posedge clk);
    #2;
    check_count++;
    if (req_ready !== 1'b0) begin
      failures++;
      $display("MISMATCH %0t ready while frozen", $time);
    end
    idle_pins();
    req_valid = 1'b0;
    clk_en = 1'b1;
    rd(17'h0_0000);
    // Random mix of writes and reads of written places
    repeat (150) begin
      a = srmc_addr_t'($urandom);
      d = srmc_data_t'($urandom);
      if ($urandom % 2) wr(a, d);
      else rd(done_q[$urandom % done_q.size()]);
    end
    req_valid = 1'b0;
    // A write taken last still needs five edges before its selects drop
    repeat (8) @(posedge clk);
    #2;
    idle_pins();
    end_of_test();
  end
  // Watchdog far beyond the fewer than two thousand cycles the tests need
  initial begin
    #2_000_000;
    failures++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_of_test();
  end
endmodule

//--- verif/srmc_sram_model.sv
// Behavioural static memory seen from its pins
`timescale 1ns/1ns
module srmc_sram_model
  import srmc_pkg::*;
(
  input  wire logic       select_low_active_n,
  input  wire logic       select_high_active,
  input  wire logic       write_n,
  input  wire logic       out_en_n,
  input  wire srmc_addr_t addr,
  input  wire srmc_data_t data_lines,
  output logic            drive,
  output srmc_data_t      q
);
  logic       sel;
  logic       wr_win;
  srmc_data_t mem [0:131071]; // One byte per 17-bit address
  // Combined select, and the write window as the overlap of select and strobe
  assign sel    = !select_low_active_n && select_high_active;
  assign wr_win = sel && !write_n;
  // Drive only in read mode; strobe low, enable high or deselect floats
  assign drive  = sel && write_n && !out_en_n;
  assign q      = mem[addr];
  // Byte taken at whichever edge closes the window
  always @(negedge wr_win) begin
    mem[addr] = data_lines;
  end
endmodule
